/* File: rtl/rxsq_pkg.sv */
/*
 * Constants, register map and carrier types of the receive shadow
 * index and receive queue register block.
 * Assumes a single 200 MHz clock and an APB master with 32-bit data.
 */
// How it works
// - shadow write with scope bit 0 updates selector and, with engine in configuration, index; with 1 only selector.
// - two-bit selector picks A seg1, A seg2, B seg1 or B seg2 index entry.
// - index field shows selected shadow header index; engine uses it to find headers.
// - each successful shadow reception updates that shadow's stored index without host.
// - queue choice bit routes first index and shape accesses to queue A or B.
// - eight-bit first index gives the header number of the queue's first buffer.
// - depth field, bits 15 to 8, sets entry count of the chosen queue.
// - size field, bits 6 to 0, sets entry data length in two-byte units.
// - read-only queue A read pointer shows next header index the host may read.
// - host acknowledges an entry by writing the not-empty flag; pointer then advances.
// - pointer past the last entry wraps back to the queue's first index.
package rxsq_pkg;

    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned IDX_W      = 8;
    localparam int unsigned SEL_W      = 2;
    localparam int unsigned SIZE_W     = 7;
    localparam int unsigned NUM_SHADOW = 4;
    localparam int unsigned EV_W       = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SHADOW = 12'h084;
    localparam logic [ADDR_W-1:0] OFF_RDPTR  = 12'h08C;
    localparam logic [ADDR_W-1:0] OFF_CHOICE = 12'h090;
    localparam logic [ADDR_W-1:0] OFF_FIRST  = 12'h094;
    localparam logic [ADDR_W-1:0] OFF_SHAPE  = 12'h098;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h09C;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 12'h0A0;
    localparam logic [ADDR_W-1:0] OFF_ACK    = 12'h0A4;

    // field positions
    localparam int unsigned SCOPE_POS  = 15;
    localparam int unsigned SEL_LSB    = 12;
    localparam int unsigned IDX_LSB    = 0;
    localparam int unsigned DEPTH_LSB  = 8;
    localparam int unsigned SIZE_LSB   = 0;
    localparam int unsigned CHOICE_POS = 0;
    localparam int unsigned ACK_POS    = 0;

    // event bits of status and mask
    localparam int unsigned EV_SHADOW = 0;
    localparam int unsigned EV_ACK    = 1;
    localparam int unsigned EV_WRAP   = 2;

    // reset values
    localparam logic [IDX_W-1:0]  RST_IDX  = 8'h00;
    localparam logic [SEL_W-1:0]  RST_SEL  = 2'h0;
    localparam logic [SIZE_W-1:0] RST_SIZE = 7'h00;
    localparam logic [EV_W-1:0]   RST_EV   = 3'h0;
    localparam logic [DATA_W-1:0] ZERO_W   = 32'h0000_0000;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic [IDX_W-1:0] index;
    } rxsq_shadow_upd_t;

    typedef struct packed {
        logic [IDX_W-1:0]  first;
        logic [IDX_W-1:0]  depth;
        logic [SIZE_W-1:0] size;
    } rxsq_queue_cfg_t;

endpackage : rxsq_pkg

/* File: rtl/rxsq_shadow_bank.sv */
/*
 * Four shadow header index entries, written by the host or by the
 * receive engine after a successful reception.
 * Assumes write and update strobes are one-cycle pulses on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module rxsq_shadow_bank
    import rxsq_pkg::*;
(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    // host write
    input  wire logic                        wr_en_i,
    input  wire logic [SEL_W-1:0]            wr_sel_i,
    input  wire logic [IDX_W-1:0]            wr_index_i,
    // engine update
    input  wire logic                        upd_valid_i,
    input  wire rxsq_shadow_upd_t            upd_i,
    // stored indices
    output logic [NUM_SHADOW*IDX_W-1:0]      index_o
);

    genvar g;
    generate
        for (g = 0; g < NUM_SHADOW; g++) begin : g_entry
            logic             hw_hit;
            logic             sw_hit;
            logic [IDX_W-1:0] idx_r;
            logic [IDX_W-1:0] idx_nxt;
            assign hw_hit  = upd_valid_i && (upd_i.sel == SEL_W'(g));
            assign sw_hit  = wr_en_i && (wr_sel_i == SEL_W'(g));
            // engine update wins over a host write in the same cycle
            assign idx_nxt = hw_hit ? upd_i.index : (sw_hit ? wr_index_i : idx_r);
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    idx_r <= RST_IDX;
                end else begin
                    idx_r <= idx_nxt;
                end
            end
            assign index_o[g*IDX_W +: IDX_W] = idx_r;

            a_hw_update: assert property (@(posedge clk_i) disable iff (!reset_n_i)
                hw_hit |=> idx_r == $past(upd_i.index))
                else $error("shadow entry missed engine update");
        end
    endgenerate

endmodule : rxsq_shadow_bank
`default_nettype wire

/* File: rtl/rxsq_regs.sv */
/*
 * APB register block: shadow index access, receive queue choice,
 * first index and shape, queue A read pointer, event status and mask.
 * Assumes an APB master with 32-bit data and a receive engine on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module rxsq_regs
    import rxsq_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    // apb slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [ADDR_W-1:0]      paddr_i,
    input  wire logic [DATA_W-1:0]      pwdata_i,
    output logic [DATA_W-1:0]           prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // receive engine
    input  wire logic                   config_state_i,
    input  wire logic                   shadow_upd_valid_i,
    input  wire rxsq_shadow_upd_t       shadow_upd_i,
    // configuration towards the engine
    output logic [NUM_SHADOW*IDX_W-1:0] shadow_index_o,
    output rxsq_queue_cfg_t             queue_a_cfg_o,
    output rxsq_queue_cfg_t             queue_b_cfg_o,
    output logic [IDX_W-1:0]            read_ptr_o,
    // interrupt
    output logic                        irq_o
);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    function automatic logic [IDX_W-1:0] ptr_advance(input logic [IDX_W-1:0] ptr,
                                                     input rxsq_queue_cfg_t   cfg);
        logic [IDX_W-1:0] last;
        last = IDX_W'(cfg.first + cfg.depth - 8'h01);
        if (cfg.depth == 8'h00 || ptr == last) begin
            ptr_advance = cfg.first;
        end else begin
            ptr_advance = IDX_W'(ptr + 8'h01);
        end
    endfunction : ptr_advance

    // registers
    logic [DATA_W-1:0]  prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [SEL_W-1:0]   shadow_sel_r;
    logic               choice_r;
    rxsq_queue_cfg_t    queue_a_r;
    rxsq_queue_cfg_t    queue_b_r;
    logic [IDX_W-1:0]   read_ptr_r;
    logic [EV_W-1:0]    status_r;
    logic [EV_W-1:0]    mask_r;
    logic               irq_r;

    // bus phase decode
    wire setup_w  = psel_i && !penable_i;
    wire commit_w = psel_i && penable_i && pready_r;
    wire wr_w     = commit_w && pwrite_i;

    wire hit_shadow = reg_hit(paddr_i, OFF_SHADOW);
    wire hit_rdptr  = reg_hit(paddr_i, OFF_RDPTR);
    wire hit_choice = reg_hit(paddr_i, OFF_CHOICE);
    wire hit_first  = reg_hit(paddr_i, OFF_FIRST);
    wire hit_shape  = reg_hit(paddr_i, OFF_SHAPE);
    wire hit_status = reg_hit(paddr_i, OFF_STATUS);
    wire hit_mask   = reg_hit(paddr_i, OFF_MASK);
    wire hit_ack    = reg_hit(paddr_i, OFF_ACK);
    wire mapped_w   = hit_shadow | hit_rdptr | hit_choice | hit_first | hit_shape
                    | hit_status | hit_mask | hit_ack;
    // read pointer is read-only: a write to it is an error
    wire err_w      = !mapped_w || (pwrite_i && hit_rdptr);

    // shadow index access
    wire [SEL_W-1:0] wr_sel_w    = pwdata_i[SEL_LSB +: SEL_W];
    wire [IDX_W-1:0] wr_idx_w    = pwdata_i[IDX_LSB +: IDX_W];
    wire             wr_shadow_w = wr_w && hit_shadow;
    // index only written with scope bit clear and engine in configuration
    wire             wr_sh_idx_w = wr_shadow_w && !pwdata_i[SCOPE_POS] && config_state_i;
    wire [IDX_W-1:0] sh_rd_idx_w = shadow_index_o[shadow_sel_r*IDX_W +: IDX_W];

    rxsq_shadow_bank u_bank (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .wr_en_i     (wr_sh_idx_w),
        .wr_sel_i    (wr_sel_w),
        .wr_index_i  (wr_idx_w),
        .upd_valid_i (shadow_upd_valid_i),
        .upd_i       (shadow_upd_i),
        .index_o     (shadow_index_o)
    );

    // queue routing through the choice bit
    wire             wr_first_w = wr_w && hit_first;
    wire             wr_shape_w = wr_w && hit_shape;
    rxsq_queue_cfg_t sel_cfg_w;
    assign sel_cfg_w = choice_r ? queue_b_r : queue_a_r;
    rxsq_queue_cfg_t cfg_wr_w;
    assign cfg_wr_w.first = wr_first_w ? pwdata_i[IDX_LSB +: IDX_W] : sel_cfg_w.first;
    assign cfg_wr_w.depth = wr_shape_w ? pwdata_i[DEPTH_LSB +: IDX_W] : sel_cfg_w.depth;
    assign cfg_wr_w.size  = wr_shape_w ? pwdata_i[SIZE_LSB +: SIZE_W] : sel_cfg_w.size;
    wire             cfg_wr_en = wr_first_w || wr_shape_w;
    wire             wr_qa_w   = cfg_wr_en && !choice_r;
    wire             wr_qb_w   = cfg_wr_en && choice_r;

    // read pointer of queue A
    wire             ack_w      = wr_w && hit_ack && pwdata_i[ACK_POS];
    wire [IDX_W-1:0] ptr_step_w = ptr_advance(read_ptr_r, queue_a_r);
    wire             wrap_w     = ack_w && (ptr_step_w == queue_a_r.first);
    // a new first index of queue A restarts the pointer
    wire             ptr_load_w = wr_first_w && !choice_r;
    wire [IDX_W-1:0] ptr_nxt    = ptr_load_w ? cfg_wr_w.first : (ack_w ? ptr_step_w : read_ptr_r);

    // events: sticky, set wins over write-one clear
    wire [EV_W-1:0] ev_set_w;
    assign ev_set_w[EV_SHADOW] = shadow_upd_valid_i;
    assign ev_set_w[EV_ACK]    = ack_w;
    assign ev_set_w[EV_WRAP]   = wrap_w;
    wire [EV_W-1:0] ev_clr_w   = (wr_w && hit_status) ? pwdata_i[EV_W-1:0] : RST_EV;
    wire [EV_W-1:0] status_nxt = (status_r & ~ev_clr_w) | ev_set_w;
    wire [EV_W-1:0] mask_nxt   = (wr_w && hit_mask) ? pwdata_i[EV_W-1:0] : mask_r;
    wire            irq_nxt    = |(status_nxt & mask_nxt);

    // read mux, sampled in setup phase
    logic [DATA_W-1:0] rd_mux_w;
    always_comb begin
        rd_mux_w = ZERO_W;
        if (hit_shadow) begin
            rd_mux_w[SEL_LSB +: SEL_W] = shadow_sel_r;
            rd_mux_w[IDX_LSB +: IDX_W] = sh_rd_idx_w;
        end
        if (hit_rdptr) begin
            rd_mux_w[IDX_LSB +: IDX_W] = read_ptr_r;
        end
        if (hit_choice) begin
            rd_mux_w[CHOICE_POS] = choice_r;
        end
        if (hit_first) begin
            rd_mux_w[IDX_LSB +: IDX_W] = sel_cfg_w.first;
        end
        if (hit_shape) begin
            rd_mux_w[DEPTH_LSB +: IDX_W] = sel_cfg_w.depth;
            rd_mux_w[SIZE_LSB +: SIZE_W] = sel_cfg_w.size;
        end
        if (hit_status) begin
            rd_mux_w[EV_W-1:0] = status_r;
        end
        if (hit_mask) begin
            rd_mux_w[EV_W-1:0] = mask_r;
        end
    end

    // bus answer: no wait state, ready in first access cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_r  <= ZERO_W;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_w;
            pslverr_r <= setup_w && err_w;
            prdata_r  <= (setup_w && !pwrite_i) ? rd_mux_w : ZERO_W;
        end
    end

    // control state
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shadow_sel_r <= RST_SEL;
            choice_r     <= 1'b0;
            queue_a_r    <= '{first: RST_IDX, depth: RST_IDX, size: RST_SIZE};
            queue_b_r    <= '{first: RST_IDX, depth: RST_IDX, size: RST_SIZE};
            read_ptr_r   <= RST_IDX;
            status_r     <= RST_EV;
            mask_r       <= RST_EV;
            irq_r        <= 1'b0;
        end else begin
            shadow_sel_r <= wr_shadow_w ? wr_sel_w : shadow_sel_r;
            choice_r     <= (wr_w && hit_choice) ? pwdata_i[CHOICE_POS] : choice_r;
            queue_a_r    <= wr_qa_w ? cfg_wr_w : queue_a_r;
            queue_b_r    <= wr_qb_w ? cfg_wr_w : queue_b_r;
            read_ptr_r   <= ptr_nxt;
            status_r     <= status_nxt;
            mask_r       <= mask_nxt;
            irq_r        <= irq_nxt;
        end
    end

    assign prdata_o      = prdata_r;
    assign pready_o      = pready_r;
    assign pslverr_o     = pslverr_r;
    assign queue_a_cfg_o = queue_a_r;
    assign queue_b_cfg_o = queue_b_r;
    assign read_ptr_o    = read_ptr_r;
    assign irq_o         = irq_r;

    // checks
    sequence s_shadow_idx_wr;
        wr_shadow_w && !pwdata_i[SCOPE_POS] && config_state_i && !shadow_upd_valid_i;
    endsequence

    sequence s_shadow_sel_wr;
        wr_shadow_w && pwdata_i[SCOPE_POS] && !shadow_upd_valid_i;
    endsequence

    a_scope_zero_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_shadow_idx_wr |=> shadow_index_o[shadow_sel_r*IDX_W +: IDX_W] == $past(pwdata_i[IDX_LSB +: IDX_W]))
        else $error("index not written with scope bit clear");

    a_scope_one_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_shadow_sel_wr |=> shadow_index_o == $past(shadow_index_o))
        else $error("index changed with scope bit set");

    a_sel_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_shadow_w |=> shadow_sel_r == $past(wr_sel_w))
        else $error("selector not updated on shadow write");

    a_shadow_read_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        setup_w && !pwrite_i && hit_shadow |=> prdata_o[SCOPE_POS] == 1'b0 && prdata_o[11:8] == 4'h0
            && prdata_o[DATA_W-1:16] == 16'h0000)
        else $error("shadow read shows nonzero unused bits");

    a_route_queue_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_first_w && !choice_r |=> queue_a_r.first == $past(pwdata_i[IDX_LSB +: IDX_W])
            && queue_b_r == $past(queue_b_r))
        else $error("first index not routed to queue A");

    a_shape_fields: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_shape_w && choice_r |=> queue_b_r.depth == $past(pwdata_i[15:8])
            && queue_b_r.size == $past(pwdata_i[6:0]))
        else $error("shape fields misplaced");

    a_ptr_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ack_w && !ptr_load_w && queue_a_r.depth != 8'h00
            && read_ptr_r != IDX_W'(queue_a_r.first + queue_a_r.depth - 8'h01)
            |=> read_ptr_o == IDX_W'($past(read_ptr_r) + 8'h01))
        else $error("read pointer did not advance on ack");

    a_ptr_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ack_w && !ptr_load_w && read_ptr_r == IDX_W'(queue_a_r.first + queue_a_r.depth - 8'h01)
            |=> read_ptr_o == $past(queue_a_r.first))
        else $error("read pointer did not wrap to first index");

    a_ptr_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !ack_w && !ptr_load_w |=> $stable(read_ptr_o))
        else $error("read pointer moved without ack");

    a_bus_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        setup_w |=> pready_o ##1 !pready_o)
        else $error("ready not a single pulse after setup");

    a_unmapped_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        setup_w && !mapped_w |=> pslverr_o && pready_o)
        else $error("unmapped access not flagged");

    a_irq_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ##1 irq_o == |($past(status_nxt) & $past(mask_nxt)))
        else $error("interrupt does not follow masked status");

    a_irq_masked: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o == |(status_r & mask_r))
        else $error("interrupt level differs from masked status");

    a_event_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        shadow_upd_valid_i |=> status_r[EV_SHADOW])
        else $error("shadow event lost against a clear");

    a_idle_rdata: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !pready_o |-> prdata_o == ZERO_W && !pslverr_o)
        else $error("read data or error shown outside an answer");

    a_rdptr_refused: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        setup_w && pwrite_i && hit_rdptr |=> pready_o && pslverr_o ##1 $stable(read_ptr_o))
        else $error("write to read pointer not refused");

    sequence s_shadow_read;
        setup_w && !pwrite_i && hit_shadow;
    endsequence

    sequence s_shadow_answer;
        pready_o && !pslverr_o && prdata_o[SEL_LSB +: SEL_W] == $past(shadow_sel_r);
    endsequence

    a_shadow_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_shadow_read |=> s_shadow_answer ##0 prdata_o[IDX_LSB +: IDX_W] == $past(sh_rd_idx_w))
        else $error("shadow read does not show selected entry");

    a_route_queue_b: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_first_w && choice_r |=> queue_b_r.first == $past(pwdata_i[IDX_LSB +: IDX_W])
            && queue_a_r == $past(queue_a_r) && $stable(read_ptr_o))
        else $error("first index not routed to queue B");

    a_shape_queue_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_shape_w && !choice_r |=> queue_a_r.depth == $past(pwdata_i[DEPTH_LSB +: IDX_W])
            && queue_a_r.size == $past(pwdata_i[SIZE_LSB +: SIZE_W]) && queue_b_r == $past(queue_b_r))
        else $error("shape not routed to queue A");

    a_first_loads_ptr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ptr_load_w |=> read_ptr_o == queue_a_r.first)
        else $error("read pointer not restarted at first index");

endmodule : rxsq_regs
`default_nettype wire

/* File: sim/rxsq_engine_model.sv */
/*
 * Receive engine stand-in: configuration state and one-cycle shadow
 * index update pulses on command of the bench.
 * Assumes clk_i and reset_n_i shared with the register block.
 */
`timescale 1ns/1ps
`default_nettype none
module rxsq_engine_model
    import rxsq_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // commands from the bench
    input  wire logic             cfg_i,
    input  wire logic             go_i,
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic [IDX_W-1:0] index_i,
    // towards the register block
    output logic                  config_state_o,
    output logic                  upd_valid_o,
    output rxsq_shadow_upd_t      upd_o
);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_state_o <= 1'b0;
            upd_valid_o    <= 1'b0;
            upd_o          <= '0;
        end else begin
            config_state_o <= cfg_i;
            upd_valid_o    <= go_i;
            // idle data toggles so a stale value is never mistaken for valid
            upd_o          <= go_i ? {sel_i, index_i} : ~upd_o;
        end
    end
endmodule : rxsq_engine_model
`default_nettype wire

/* File: sim/rx_shadow_and_fifo_index_regs_bench.sv */
/*
 * Self-checking bench of the receive shadow and queue register block.
 * Assumes rxsq_regs and the engine stand-in, one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rx_shadow_and_fifo_index_regs_bench
    import rxsq_pkg::*;
;
    logic                  clk_i;
    logic                  reset_n_i;
    logic                  psel_i;
    logic                  penable_i;
    logic                  pwrite_i;
    logic [ADDR_W-1:0]     paddr_i;
    logic [DATA_W-1:0]     pwdata_i;
    logic [DATA_W-1:0]     prdata_o;
    logic                  pready_o;
    logic                  pslverr_o;
    logic                  config_state_i;
    logic                  shadow_upd_valid_i;
    rxsq_shadow_upd_t      shadow_upd_i;
    logic [31:0]           shadow_index_o;
    rxsq_queue_cfg_t       queue_a_cfg_o;
    rxsq_queue_cfg_t       queue_b_cfg_o;
    logic [IDX_W-1:0]      read_ptr_o;
    logic                  irq_o;
    logic                  cfg_req;
    logic                  go;
    logic [SEL_W-1:0]      go_sel;
    logic [IDX_W-1:0]      go_idx;
    logic [31:0]           rd;
    logic                  err;
    int                    fail_count;
    int                    comparisons;

    rxsq_regs dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .config_state_i(config_state_i),
        .shadow_upd_valid_i(shadow_upd_valid_i), .shadow_upd_i(shadow_upd_i),
        .shadow_index_o(shadow_index_o), .queue_a_cfg_o(queue_a_cfg_o),
        .queue_b_cfg_o(queue_b_cfg_o), .read_ptr_o(read_ptr_o), .irq_o(irq_o));

    rxsq_engine_model engine_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_req), .go_i(go), .sel_i(go_sel),
        .index_i(go_idx), .config_state_o(config_state_i), .upd_valid_o(shadow_upd_valid_i),
        .upd_o(shadow_upd_i));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                fail_count++;
                final_report();
            end
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0000_0000, err}, 32'h0000_0000);
    endtask : rchk

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    initial begin
        reset_n_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = '0;
        cfg_req = 1'b1;
        go = 1'b0;
        go_sel = '0;
        go_idx = '0;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // reset values
        rchk(OFF_SHADOW, 32'h0000_0000);
        rchk(OFF_RDPTR, 32'h0000_0000);
        rchk(OFF_CHOICE, 32'h0000_0000);
        rchk(OFF_FIRST, 32'h0000_0000);
        rchk(OFF_SHAPE, 32'h0000_0000);
        // full writes per selector, then selector-only writes and readback
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, OFF_SHADOW, 32'h0000_0030 + 32'(g) + (32'(g) << 12));
        end
        settle(1);
        chk(shadow_index_o, 32'h3332_3130);
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, OFF_SHADOW, 32'h0000_80FF + (32'(g) << 12));
            rchk(OFF_SHADOW, 32'h0000_0030 + 32'(g) + (32'(g) << 12));
        end
        // index write outside configuration is ignored
        cfg_req <= 1'b0;
        apb(1'b1, OFF_SHADOW, 32'h0000_0077);
        settle(1);
        chk(shadow_index_o, 32'h3332_3130);
        cfg_req <= 1'b1;
        // engine update and its interrupt
        apb(1'b1, OFF_STATUS, 32'h0000_0007);
        apb(1'b1, OFF_MASK, 32'h0000_0001);
        rchk(OFF_MASK, 32'h0000_0001);
        go_sel <= 2'h2;
        go_idx <= 8'h5A;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        settle(3);
        chk(shadow_index_o, 32'h335A_3130);
        chk({31'h0000_0000, irq_o}, 32'h0000_0001);
        rchk(OFF_STATUS, 32'h0000_0001);
        apb(1'b1, OFF_STATUS, 32'h0000_0001);
        settle(2);
        chk({31'h0000_0000, irq_o}, 32'h0000_0000);
        // queue layouts through the choice bit
        apb(1'b1, OFF_CHOICE, 32'h0000_0000);
        apb(1'b1, OFF_FIRST, 32'h0000_0020);
        apb(1'b1, OFF_SHAPE, 32'h0000_0395);
        apb(1'b1, OFF_CHOICE, 32'h0000_0001);
        apb(1'b1, OFF_FIRST, 32'h0000_0040);
        apb(1'b1, OFF_SHAPE, 32'h0000_0A7F);
        settle(1);
        chk({9'h000, queue_a_cfg_o}, {9'h000, 8'h20, 8'h03, 7'h15});
        chk({9'h000, queue_b_cfg_o}, {9'h000, 8'h40, 8'h0A, 7'h7F});
        rchk(OFF_FIRST, 32'h0000_0040);
        rchk(OFF_SHAPE, 32'h0000_0A7F);
        rchk(OFF_CHOICE, 32'h0000_0001);
        apb(1'b1, OFF_CHOICE, 32'h0000_0000);
        rchk(OFF_FIRST, 32'h0000_0020);
        rchk(OFF_SHAPE, 32'h0000_0315);
        // read pointer steps through three entries and wraps
        rchk(OFF_RDPTR, 32'h0000_0020);
        for (int k = 1; k <= 3; k++) begin
            apb(1'b1, OFF_ACK, 32'h0000_0001);
            rchk(OFF_RDPTR, 32'h0000_0020 + 32'(k % 3));
        end
        apb(1'b1, OFF_ACK, 32'h0000_00FE);
        chk({24'h00_0000, read_ptr_o}, 32'h0000_0020);
        rchk(OFF_STATUS, 32'h0000_0006);
        chk({31'h0000_0000, irq_o}, 32'h0000_0000);
        // refused accesses
        apb(1'b1, OFF_RDPTR, 32'h0000_00FF);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        rchk(OFF_RDPTR, 32'h0000_0020);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        final_report();
    end
endmodule : rx_shadow_and_fifo_index_regs_bench
`default_nettype wire
